// ===== logic/tlirq_ctrl.sv
/*
 * Two-level interrupt controller with an optional remap network.
 * Assumes APB (no ready signal) from a single bridge, interrupt
 * sources synchronous to i_clk, and an integer unit that
 * acknowledges with the number it took.
 */
`timescale 1ns/100ps
module tlirq_ctrl #(
    parameter int NUM_IRQ = 15,
    parameter bit REMAP_EN = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    input wire logic [NUM_IRQ:1] i_bus_irq,
    output logic [3:0] o_irl,
    input wire logic i_intack,
    input wire logic [3:0] i_ack_irl
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tlirq_pkg::tlirq_vec_t enable_mask_bits;
        tlirq_pkg::tlirq_vec_t priority_level_bits;
        tlirq_pkg::tlirq_vec_t pending_bits;
        tlirq_pkg::tlirq_vec_t force_bits;
        tlirq_pkg::tlirq_map_t route_field;
        logic [3:0] irl;
        logic [31:0] rdata;
    } tlirq_state_t;

    tlirq_state_t state_ff;
    tlirq_state_t nxt_state;

    logic [NUM_IRQ:1] routed_irq;
    logic [NUM_IRQ:1] source_event;
    logic wr_en;
    logic rd_setup;
    logic [NUM_IRQ:1] ack_onehot;
    logic [NUM_IRQ:1] unmasked;
    logic [NUM_IRQ:1] req_hi;
    logic [NUM_IRQ:1] req_lo;
    logic [3:0] best_hi;
    logic [3:0] best_lo;
    logic [3:0] nxt_irl;

    // ----------------------------------------------------------------
    // Source routing
    // ----------------------------------------------------------------
    tlirq_remap #(
        .NUM_IRQ(NUM_IRQ)
    ) u_remap (
        .i_bus_irq(i_bus_irq),
        .i_route_field(state_ff.route_field),
        .o_cpu_irq(routed_irq)
    );

    // Without the option the switch is bypassed and left for synthesis to trim
    assign source_event = REMAP_EN ? routed_irq : i_bus_irq;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign wr_en = i_psel & i_penable & i_pwrite;
    // Read data is captured in the setup phase so it is stable in access
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;

    // ----------------------------------------------------------------
    // Priority selection
    // ----------------------------------------------------------------
    function automatic logic [3:0] highest(input logic [NUM_IRQ:1] req);
        logic [3:0] num;
        num = tlirq_pkg::IRL_NONE;
        for (int i = 1; i <= NUM_IRQ; i++) begin
            if (req[i]) begin
                num = 4'(i);
            end
        end
        return num;
    endfunction

    always_comb begin
        unmasked = (state_ff.pending_bits | state_ff.force_bits)
            & state_ff.enable_mask_bits;
        // Remapping replaces the level scheme, so all requests rank on one level
        if (REMAP_EN) begin
            req_hi = '0;
        end else begin
            req_hi = unmasked & state_ff.priority_level_bits;
        end
        req_lo = unmasked & ~req_hi;
        best_hi = highest(req_hi);
        best_lo = highest(req_lo);
        if (best_hi != tlirq_pkg::IRL_NONE) begin
            nxt_irl = best_hi;
        end else begin
            nxt_irl = best_lo;
        end
    end

    // ----------------------------------------------------------------
    // Acknowledge decode
    // ----------------------------------------------------------------
    always_comb begin
        ack_onehot = '0;
        for (int i = 1; i <= NUM_IRQ; i++) begin
            if (i_intack && i_ack_irl == 4'(i)) begin
                ack_onehot[i] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.irl = nxt_irl;

        // Register writes
        if (wr_en) begin
            case (i_paddr)
                tlirq_pkg::ADDR_MASK_LEVEL: begin
                    nxt_state.enable_mask_bits =
                        i_pwdata[tlirq_pkg::MASK_LSB +: NUM_IRQ];
                    nxt_state.priority_level_bits =
                        i_pwdata[tlirq_pkg::LEVEL_LSB +: NUM_IRQ];
                end
                tlirq_pkg::ADDR_PENDING: begin
                    nxt_state.pending_bits = i_pwdata[NUM_IRQ:1];
                end
                tlirq_pkg::ADDR_FORCE: begin
                    nxt_state.force_bits = i_pwdata[NUM_IRQ:1];
                end
                tlirq_pkg::ADDR_CLEAR: begin
                    nxt_state.pending_bits =
                        state_ff.pending_bits & ~i_pwdata[NUM_IRQ:1];
                end
                tlirq_pkg::ADDR_MAP_LOW: begin
                    if (REMAP_EN) begin
                        for (int k = 0; k < tlirq_pkg::FIELDS_PER_REG; k++) begin
                            nxt_state.route_field[k + 1] = i_pwdata[
                                tlirq_pkg::MAP_TOP_LSB - 4 * k +: 4];
                        end
                    end
                end
                tlirq_pkg::ADDR_MAP_HIGH: begin
                    if (REMAP_EN) begin
                        for (int k = 0; k < tlirq_pkg::FIELDS_PER_REG; k++) begin
                            nxt_state.route_field[k + 8] = i_pwdata[
                                tlirq_pkg::MAP_TOP_LSB - 4 * k +: 4];
                        end
                        nxt_state.route_field[NUM_IRQ] =
                            i_pwdata[tlirq_pkg::MAP_LINE15_LSB +: 4];
                    end
                end
                default: begin
                end
            endcase
        end

        // Acknowledge: a forced request only gives up its force bit
        for (int i = 1; i <= NUM_IRQ; i++) begin
            if (ack_onehot[i]) begin
                if (state_ff.force_bits[i]) begin
                    nxt_state.force_bits[i] = 1'b0;
                end else begin
                    nxt_state.pending_bits[i] = 1'b0;
                end
            end
        end

        // Events last so a set in the clearing cycle is never lost
        nxt_state.pending_bits = nxt_state.pending_bits | source_event;

        // Read data
        if (rd_setup) begin
            case (i_paddr)
                tlirq_pkg::ADDR_MASK_LEVEL: begin
                    nxt_state.rdata = '0;
                    nxt_state.rdata[tlirq_pkg::LEVEL_LSB +: NUM_IRQ] =
                        state_ff.priority_level_bits;
                    nxt_state.rdata[tlirq_pkg::MASK_LSB +: NUM_IRQ] =
                        state_ff.enable_mask_bits;
                end
                tlirq_pkg::ADDR_PENDING: begin
                    nxt_state.rdata = {16'h0000, state_ff.pending_bits, 1'b0};
                end
                tlirq_pkg::ADDR_FORCE: begin
                    nxt_state.rdata = {16'h0000, state_ff.force_bits, 1'b0};
                end
                tlirq_pkg::ADDR_MAP_LOW: begin
                    nxt_state.rdata = '0;
                    if (REMAP_EN) begin
                        for (int k = 0; k < tlirq_pkg::FIELDS_PER_REG; k++) begin
                            nxt_state.rdata[tlirq_pkg::MAP_TOP_LSB - 4 * k +: 4] =
                                state_ff.route_field[k + 1];
                        end
                    end
                end
                tlirq_pkg::ADDR_MAP_HIGH: begin
                    nxt_state.rdata = '0;
                    if (REMAP_EN) begin
                        for (int k = 0; k < tlirq_pkg::FIELDS_PER_REG; k++) begin
                            nxt_state.rdata[tlirq_pkg::MAP_TOP_LSB - 4 * k +: 4] =
                                state_ff.route_field[k + 8];
                        end
                        nxt_state.rdata[tlirq_pkg::MAP_LINE15_LSB +: 4] =
                            state_ff.route_field[NUM_IRQ];
                    end
                end
                // Clear register and unmapped addresses read zero
                default: begin
                    nxt_state.rdata = '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Level, pending and force have no defined reset value; zero is used
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff.enable_mask_bits <= tlirq_pkg::MASK_RESET;
            state_ff.priority_level_bits <= tlirq_pkg::LEVEL_RESET;
            state_ff.pending_bits <= tlirq_pkg::PEND_RESET;
            state_ff.force_bits <= tlirq_pkg::FORCE_RESET;
            state_ff.route_field <= tlirq_pkg::map_identity();
            state_ff.irl <= tlirq_pkg::IRL_NONE;
            state_ff.rdata <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_irl = state_ff.irl;
    assign o_prdata = state_ff.rdata;

endmodule

// ===== logic/tlirq_pkg.sv
/*
 * Constants, field layouts and types for the two-level interrupt
 * controller with optional line remapping.
 * Assumes an APB bridge as the only bus master and an integer unit
 * that takes a four-bit request level and acknowledges it.
 */
package tlirq_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses on the peripheral bus
    // ----------------------------------------------------------------
    localparam logic [31:0] ADDR_MASK_LEVEL = 32'h8000_0090;
    localparam logic [31:0] ADDR_PENDING = 32'h8000_0094;
    localparam logic [31:0] ADDR_FORCE = 32'h8000_0098;
    localparam logic [31:0] ADDR_CLEAR = 32'h8000_009c;
    localparam logic [31:0] ADDR_MAP_LOW = 32'h8000_00e0;
    localparam logic [31:0] ADDR_MAP_HIGH = 32'h8000_00e4;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int NUM_IRQ = 15;
    localparam int LEVEL_LSB = 17;
    localparam int MASK_LSB = 1;
    localparam int FIELD_W = 4;
    localparam int FIELDS_PER_REG = 7;
    // Top field of each map register starts here
    localparam int MAP_TOP_LSB = 24;
    // Line 15 has no slot in the printed layout; it uses the high nibble
    localparam int MAP_LINE15_LSB = 28;

    // ----------------------------------------------------------------
    // Types and reset values
    // ----------------------------------------------------------------
    typedef logic [NUM_IRQ:1] tlirq_vec_t;
    typedef logic [NUM_IRQ:1][FIELD_W-1:0] tlirq_map_t;

    localparam tlirq_vec_t MASK_RESET = 15'h0000;
    localparam tlirq_vec_t LEVEL_RESET = 15'h0000;
    localparam tlirq_vec_t PEND_RESET = 15'h0000;
    localparam tlirq_vec_t FORCE_RESET = 15'h0000;
    localparam logic [3:0] IRL_NONE = 4'h0;

    // Identity routing: field i holds i
    function automatic tlirq_map_t map_identity();
        tlirq_map_t m;
        for (int i = 1; i <= NUM_IRQ; i++) begin
            m[i] = FIELD_W'(i);
        end
        return m;
    endfunction

endpackage

// ===== logic/tlirq_remap.sv
/*
 * Switch network that routes each bus interrupt line onto the
 * processor interrupt line chosen by its map field.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps
module tlirq_remap #(
    parameter int NUM_IRQ = 15
) (
    input wire logic [NUM_IRQ:1] i_bus_irq,
    input wire tlirq_pkg::tlirq_map_t i_route_field,
    output logic [NUM_IRQ:1] o_cpu_irq
);

    // ----------------------------------------------------------------
    // One OR tree per processor line
    // ----------------------------------------------------------------
    // A field of zero routes nowhere, so that bus line is dropped
    for (genvar y = 1; y <= NUM_IRQ; y++) begin : g_line
        always_comb begin
            o_cpu_irq[y] = 1'b0;
            for (int x = 1; x <= NUM_IRQ; x++) begin
                if (i_route_field[x] == 4'(y)) begin
                    o_cpu_irq[y] = o_cpu_irq[y] | i_bus_irq[x];
                end
            end
        end
    end

endmodule

// ===== verif/tlirq_assertions.sv
/* Port checker for tlirq_ctrl.
   Assumes it is bound to the controller and sees only its ports. */
`timescale 1ns/100ps
module tlirq_assertions #(
    parameter int NUM_IRQ = 15,
    parameter bit REMAP_EN = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic [NUM_IRQ:1] i_bus_irq,
    input wire logic [3:0] o_irl,
    input wire logic i_intack,
    input wire logic [3:0] i_ack_irl
);
    // ------------------------------------------------------------
    // Shadow of the mask and level register
    // ------------------------------------------------------------
    logic [31:0] ml_ff;
    logic [15:0] mk;
    logic rd_set;
    logic known;
    assign mk = ml_ff[15:0];
    assign rd_set = i_psel && !i_penable && !i_pwrite;
    assign known = i_paddr inside {tlirq_pkg::ADDR_MASK_LEVEL, tlirq_pkg::ADDR_PENDING,
        tlirq_pkg::ADDR_FORCE, tlirq_pkg::ADDR_MAP_LOW, tlirq_pkg::ADDR_MAP_HIGH};
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ml_ff <= 32'h0;
        end else if (i_psel && i_penable && i_pwrite
                && i_paddr == tlirq_pkg::ADDR_MASK_LEVEL) begin
            ml_ff <= i_pwdata & 32'hfffe_fffe;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    rst_irl_a: assert property ($rose(i_rst_n) |-> o_irl == 4'h0)
        else $error("request not idle after reset");
    mask_level_a: assert property (rd_set && i_paddr == tlirq_pkg::ADDR_MASK_LEVEL
        |=> o_prdata == $past(ml_ff))
        else $error("mask and level readback wrong");
    clear_read_a: assert property (rd_set && i_paddr == tlirq_pkg::ADDR_CLEAR
        |=> o_prdata == 32'h0)
        else $error("clear register read not zero");
    unmapped_read_a: assert property (rd_set && !known |=> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    pend_resv_a: assert property (rd_set && i_paddr == tlirq_pkg::ADDR_PENDING
        |=> o_prdata[31:16] == 16'h0 && !o_prdata[0])
        else $error("pending reserved bits set");
    force_resv_a: assert property (rd_set && i_paddr == tlirq_pkg::ADDR_FORCE
        |=> o_prdata[31:16] == 16'h0 && !o_prdata[0])
        else $error("force reserved bits set");
    irl_masked_a: assert property (o_irl != 4'h0
        |-> (($past(mk) >> o_irl) & 16'h1) != 16'h0)
        else $error("masked request presented");
    event_req_a: assert property ((i_bus_irq & mk[NUM_IRQ:1]) != '0 |-> ##2 o_irl != 4'h0)
        else $error("enabled event not presented");
    prdata_hold_a: assert property (!rd_set |=> $stable(o_prdata))
        else $error("read data changed outside setup");
    cover property (rd_set);
    cover property (i_intack);
    cover property (o_irl == 4'hf);
endmodule
bind tlirq_ctrl tlirq_assertions #(.NUM_IRQ(NUM_IRQ), .REMAP_EN(REMAP_EN)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .i_bus_irq(i_bus_irq), .o_irl(o_irl), .i_intack(i_intack), .i_ack_irl(i_ack_irl));

// ===== verif/tlirq_iu_model.sv
/* Integer unit model: takes the request number and acknowledges it.
   Assumes a registered request that settles one edge after an ack. */
`timescale 1ns/100ps
module tlirq_iu_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    input wire logic [3:0] i_delay,
    input wire logic [3:0] i_irl,
    output logic o_intack,
    output logic [3:0] o_ack_irl
);
    initial begin
        o_intack = 1'b0;
        o_ack_irl = 4'h0;
        forever begin
            @(posedge i_clk);
            if (i_rst_n && i_en && i_irl != 4'h0) begin
                repeat (i_delay) @(posedge i_clk);
                // Every number is taken, 15 included: no mask here
                o_intack <= 1'b1;
                o_ack_irl <= i_irl;
                @(posedge i_clk);
                o_intack <= 1'b0;
                o_ack_irl <= ~o_ack_irl;
                // Extra edge so the old number is not taken twice
                @(posedge i_clk);
            end
        end
    end
endmodule

// ===== verif/testbench.sv
/* Self-checking bench for tlirq_ctrl: a plain and a remapped build share one bus.
   Assumes the integer unit model file is compiled first. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
    logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_intack, iu_en;
    logic [31:0] i_paddr, i_pwdata, o_prdata, rd, o_prdata_r, rd_r;
    logic [15:1] i_bus_irq;
    logic [3:0] o_irl, i_ack_irl, iu_dly, o_irl_r;
    logic [3:0] acks[$];
    int mismatches, comparisons;
    tlirq_ctrl u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .i_bus_irq(i_bus_irq), .o_irl(o_irl), .i_intack(i_intack),
        .i_ack_irl(i_ack_irl));
    // Remap build: map registers live, level bits ignored
    tlirq_ctrl #(.NUM_IRQ(15), .REMAP_EN(1'b1)) u_dut_remap (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata_r), .i_bus_irq(i_bus_irq),
        .o_irl(o_irl_r), .i_intack(i_intack), .i_ack_irl(i_ack_irl));
    tlirq_iu_model u_iu (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(iu_en), .i_delay(iu_dly),
        .i_irl(o_irl), .o_intack(i_intack), .o_ack_irl(i_ack_irl));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (i_intack) acks.push_back(i_ack_irl);
    // ------------------------------------------------------------
    // Bus and wait helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        rd = o_prdata;
        rd_r = o_prdata_r;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic pulse(input logic [15:1] v);
        @(posedge i_clk);
        i_bus_irq <= v;
        @(posedge i_clk);
        i_bus_irq <= 15'h0;
        repeat (3) @(posedge i_clk);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_acks(input int n);
        for (int i = 0; i < 60 && acks.size() < n; i++) @(posedge i_clk);
        if (acks.size() < n) begin
            mismatches++;
            conclude();
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, tlirq_pkg::ADDR_MASK_LEVEL, 32'h0);
        `CHK("mask after reset", 32'h0, rd)
        apb(1'b1, tlirq_pkg::ADDR_MASK_LEVEL, 32'hffff_ffff);
        apb(1'b0, tlirq_pkg::ADDR_MASK_LEVEL, 32'h0);
        `CHK("mask level", 32'hfffe_fffe, rd)
        apb(1'b1, tlirq_pkg::ADDR_CLEAR, 32'hffff_ffff);
        apb(1'b0, tlirq_pkg::ADDR_CLEAR, 32'h0);
        `CHK("clear read", 32'h0, rd)
        apb(1'b0, 32'h8000_00a0, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
    endtask
    task automatic t_prio();
        // Source 3 alone on level 1, all enabled
        apb(1'b1, tlirq_pkg::ADDR_MASK_LEVEL, 32'h0008_fffe);
        pulse(15'h4104);
        `CHK("level one wins", 4'h3, o_irl)
        apb(1'b0, tlirq_pkg::ADDR_PENDING, 32'h0);
        `CHK("pending", 32'h0000_8208, rd)
        iu_dly <= 4'h0;
        iu_en <= 1'b1;
        wait_acks(3);
        iu_en <= 1'b0;
        `CHK("ack order", 12'h3f9, {acks[0], acks[1], acks[2]})
        repeat (3) @(posedge i_clk);
        `CHK("idle request", 4'h0, o_irl)
        apb(1'b0, tlirq_pkg::ADDR_PENDING, 32'h0);
        `CHK("pending acked", 32'h0, rd)
    endtask
    task automatic t_force();
        apb(1'b1, tlirq_pkg::ADDR_FORCE, 32'h0000_0020);
        repeat (2) @(posedge i_clk);
        `CHK("force raises", 4'h5, o_irl)
        pulse(15'h0010);
        `CHK("forced request", 4'h5, o_irl)
        acks.delete();
        iu_dly <= 4'h3;
        iu_en <= 1'b1;
        wait_acks(1);
        iu_en <= 1'b0;
        apb(1'b0, tlirq_pkg::ADDR_FORCE, 32'h0);
        `CHK("force cleared", 32'h0, rd)
        apb(1'b0, tlirq_pkg::ADDR_PENDING, 32'h0);
        `CHK("pending kept", 32'h0000_0020, rd)
        apb(1'b1, tlirq_pkg::ADDR_MASK_LEVEL, 32'h0);
        repeat (2) @(posedge i_clk);
        `CHK("masked request", 4'h0, o_irl)
        apb(1'b1, tlirq_pkg::ADDR_CLEAR, 32'h0000_0020);
        apb(1'b0, tlirq_pkg::ADDR_PENDING, 32'h0);
        `CHK("pending cleared", 32'h0, rd)
    endtask
    task automatic t_remap();
        apb(1'b0, tlirq_pkg::ADDR_MAP_LOW, 32'h0);
        `CHK("map low reset", 32'h0123_4567, rd_r)
        apb(1'b0, tlirq_pkg::ADDR_MAP_HIGH, 32'h0);
        `CHK("map high reset", 32'hf89a_bcde, rd_r)
        `CHK("map absent", 32'h0, rd)
        apb(1'b1, tlirq_pkg::ADDR_MASK_LEVEL, 32'h0000_fffe);
        // Lines 1 and 2 both onto processor line 6
        apb(1'b1, tlirq_pkg::ADDR_MAP_LOW, 32'h0663_4567);
        apb(1'b0, tlirq_pkg::ADDR_MAP_LOW, 32'h0);
        `CHK("map write", 32'h0663_4567, rd_r)
        pulse(15'h0002);
        `CHK("routed request", 4'h6, o_irl_r)
        `CHK("plain request", 4'h2, o_irl)
        apb(1'b0, tlirq_pkg::ADDR_PENDING, 32'h0);
        `CHK("routed pending", 32'h0000_0040, rd_r)
        `CHK("plain pending", 32'h0000_0004, rd)
    endtask
    initial begin
        i_rst_n = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 32'h0;
        i_pwdata = 32'h0;
        i_bus_irq = 15'h0;
        iu_en = 1'b0;
        iu_dly = 4'h0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_prio();
        t_force();
        t_remap();
        conclude();
    end
endmodule
